/* File: design/cmo_core.sv */
`timescale 1ns/1ps
module cmo_core #(
  parameter int GPR_BANKS = cmo_pkg::GPR_BANKS
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic ce,
  input wire cmo_pkg::cmo_dreq_s dreq,
  output logic busy,
  output logic [7:0] rd_data,
  output logic rd_valid,
  input wire cmo_pkg::cmo_alu_s alu,
  output logic [7:0] alu_result,
  input wire cmo_pkg::cmo_pc_e pc_op,
  input wire logic [cmo_pkg::PC_W-1:0] pc_target,
  output logic [cmo_pkg::PC_W-1:0] pc,
  output logic pm_rd,
  output logic [cmo_pkg::PM_AW-1:0] pm_addr,
  input wire logic [cmo_pkg::PM_DW-1:0] pm_rdata,
  output logic pm_hef_sel,
  input wire logic wdt_clear_op,
  input wire logic sleep_op,
  input wire logic wdt_timeout,
  input wire logic stack_reset_en,
  input wire logic [1:0] stack_flag_clr,
  output logic stack_overflow_flag,
  output logic stack_underflow_flag,
  output logic soft_reset_req,
  output logic [7:0] status,
  output logic [7:0] accumulator
);
  import cmo_pkg::*;

  localparam int GPR_N = GPR_BANKS * GPR_BYTES;
  localparam int GI_W = $clog2(GPR_N);

  typedef enum logic {CMO_IDLE, CMO_PM_WAIT} cmo_state_e;

  cmo_state_e state_reg;
  logic [7:0] status_reg;
  logic [7:0] acc_reg;
  logic [BANK_W-1:0] bank_reg;
  logic [LATCH_W-1:0] latch_reg;
  logic [7:0] int_ctrl_reg;
  logic [PTR_W-1:0] pa_reg;
  logic [PTR_W-1:0] pb_reg;
  logic [PC_W-1:0] pc_reg;
  cmo_shadow_s shadow_reg;
  logic [7:0] general_ram_area [GPR_N];
  logic [7:0] common [COMMON_BYTES];
  logic pm_is_rd_reg;
  logic [PM_AW-1:0] pm_addr_reg;
  logic [7:0] rd_data_reg;
  logic rd_valid_reg;
  logic [7:0] alu_res_reg;
  logic ovf_flag_reg;
  logic unf_flag_reg;
  logic soft_rst_reg;

  logic take;
  logic sel_ind;
  logic [PTR_W-1:0] ptr;
  logic pm_access;
  logic [BANK_W-1:0] eff_bank;
  logic [OFF_W-1:0] eff_off;
  logic nested;
  logic wr_ok;
  logic gpr_hit;
  logic [GI_W-1:0] gpr_idx;
  logic [7:0] rd_mux;
  logic [7:0] alu_res;
  logic alu_z;
  logic alu_nib;
  logic alu_c;
  logic pc_low_wr;
  logic status_wr;
  logic irq_take;
  logic restore;
  logic stk_push;
  logic stk_pop;
  logic [PC_W-1:0] stk_push_data;
  logic [PC_W-1:0] stk_top;
  logic stk_ovf;
  logic stk_unf;

  function automatic logic [PC_W-1:0] wrap_pc(input logic [PC_W-1:0] a);
    return {{(PC_W-PM_AW){1'b0}}, a[PM_AW-1:0]};
  endfunction

  // ==========================================================
  // address formation
  // ==========================================================
  assign take = ce && dreq.valid && state_reg == CMO_IDLE;
  assign sel_ind = dreq.addr == OFF_IND_A || dreq.addr == OFF_IND_B;
  assign ptr = dreq.addr[0] ? pb_reg : pa_reg;
  assign pm_access = sel_ind && ptr[8 + PTR_PM_BIT];
  assign eff_bank = sel_ind ? ptr[DA_W-1:OFF_W] : bank_reg;
  assign eff_off = sel_ind ? ptr[OFF_W-1:0] : dreq.addr;
  assign nested = sel_ind && (eff_off == OFF_IND_A || eff_off == OFF_IND_B);
  assign wr_ok = take && dreq.wr && !pm_access && !nested;
  assign pc_low_wr = wr_ok && eff_off == OFF_PC_LOW;
  assign status_wr = wr_ok && eff_off == OFF_STATUS;
  assign irq_take = ce && pc_op == CMO_PC_IRQ;
  assign restore = ce && pc_op == CMO_PC_RETFIE;

  always_comb
  begin
    int idx;
    idx = 0;
    gpr_hit = 1'b0;
    if (eff_off >= OFF_GPR_LO && eff_off <= OFF_GPR_HI && int'(eff_bank) < GPR_BANKS)
    begin
      gpr_hit = 1'b1;
      idx = int'(eff_bank) * GPR_BYTES + int'(eff_off - OFF_GPR_LO);
    end
    gpr_idx = GI_W'(idx);
  end

  // core registers answer on the low seven bits whatever the bank
  always_comb
  begin
    rd_mux = 8'h00;
    if (!nested)
    begin
      case (eff_off)
        OFF_PC_LOW: rd_mux = pc_reg[7:0];
        OFF_STATUS: rd_mux = status_reg;
        OFF_PA_LO: rd_mux = pa_reg[7:0];
        OFF_PA_HI: rd_mux = pa_reg[15:8];
        OFF_PB_LO: rd_mux = pb_reg[7:0];
        OFF_PB_HI: rd_mux = pb_reg[15:8];
        OFF_BANK: rd_mux = {3'h0, bank_reg};
        OFF_ACC: rd_mux = acc_reg;
        OFF_LATCH: rd_mux = {1'b0, latch_reg};
        OFF_INT_CTRL: rd_mux = int_ctrl_reg;
        default:
        begin
          if (eff_off >= OFF_COMMON_LO)
          begin
            rd_mux = common[eff_off[3:0]];
          end
          else if (gpr_hit)
          begin
            rd_mux = general_ram_area[gpr_idx];
          end
        end
      endcase
    end
  end

  // ==========================================================
  // data memory
  // ==========================================================
  always_ff @(posedge clk)
  begin
    if (wr_ok && eff_off >= OFF_COMMON_LO)
    begin
      common[eff_off[3:0]] <= dreq.wdata;
    end
    else if (wr_ok && gpr_hit)
    begin
      general_ram_area[gpr_idx] <= dreq.wdata;
    end
  end

  // ==========================================================
  // read answer and program memory fetch
  // ==========================================================
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      state_reg <= CMO_IDLE;
      pm_is_rd_reg <= 1'b0;
      pm_addr_reg <= '0;
      rd_data_reg <= 8'h00;
      rd_valid_reg <= 1'b0;
    end
    else if (ce)
    begin
      rd_valid_reg <= 1'b0;
      case (state_reg)
        CMO_IDLE:
        begin
          if (take && pm_access)
          begin
            state_reg <= CMO_PM_WAIT;
            pm_is_rd_reg <= !dreq.wr;
            pm_addr_reg <= ptr[PM_AW-1:0];
          end
          else if (take && !dreq.wr)
          begin
            rd_data_reg <= rd_mux;
            rd_valid_reg <= 1'b1;
          end
        end
        CMO_PM_WAIT:
        begin
          state_reg <= CMO_IDLE;
          if (pm_is_rd_reg)
          begin
            rd_data_reg <= pm_rdata[7:0];
            rd_valid_reg <= 1'b1;
          end
        end
        default: state_reg <= CMO_IDLE;
      endcase
    end
  end

  assign busy = state_reg == CMO_PM_WAIT;
  assign pm_rd = busy && pm_is_rd_reg;
  assign pm_addr = pm_addr_reg;
  assign pm_hef_sel = pm_rd && pm_addr_reg >= HEF_LO && pm_addr_reg <= PM_LAST;
  assign rd_data = rd_data_reg;
  assign rd_valid = rd_valid_reg;

  // ==========================================================
  // flag logic
  // ==========================================================
  always_comb
  begin
    logic [8:0] sum;
    logic [4:0] nib;
    sum = 9'h000;
    nib = 5'h00;
    alu_res = alu.a;
    alu_c = status_reg[ST_C];
    alu_nib = status_reg[ST_NIB];
    case (alu.kind)
      CMO_ALU_ADD:
      begin
        sum = {1'b0, alu.a} + {1'b0, alu.b};
        nib = {1'b0, alu.a[3:0]} + {1'b0, alu.b[3:0]};
      end
      CMO_ALU_SUB:
      begin
        sum = {1'b0, alu.a} + {1'b0, ~alu.b} + 9'h001;
        nib = {1'b0, alu.a[3:0]} + {1'b0, ~alu.b[3:0]} + 5'h01;
      end
      CMO_ALU_RLF: alu_res = {alu.a[6:0], status_reg[ST_C]};
      CMO_ALU_RRF: alu_res = {status_reg[ST_C], alu.a[7:1]};
      default: alu_res = alu.a;
    endcase
    if (alu.kind == CMO_ALU_ADD || alu.kind == CMO_ALU_SUB)
    begin
      alu_res = sum[7:0];
      alu_c = sum[8];
      alu_nib = nib[4];
    end
    else if (alu.kind == CMO_ALU_RLF)
    begin
      alu_c = alu.a[7];
    end
    else if (alu.kind == CMO_ALU_RRF)
    begin
      alu_c = alu.a[0];
    end
    alu_z = status_reg[ST_Z];
    if (alu.kind == CMO_ALU_ADD || alu.kind == CMO_ALU_SUB || alu.kind == CMO_ALU_LOGIC)
    begin
      alu_z = alu_res == 8'h00;
    end
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      alu_res_reg <= 8'h00;
    end
    else if (ce && alu.valid)
    begin
      alu_res_reg <= alu_res;
    end
  end

  assign alu_result = alu_res_reg;

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      status_reg <= STATUS_RST;
    end
    else if (ce)
    begin
      if (alu.valid)
      begin
        status_reg[2:0] <= {alu_z, alu_nib, alu_c};
      end
      else if (restore)
      begin
        status_reg[2:0] <= shadow_reg.flags;
      end
      else if (status_wr)
      begin
        status_reg[2:0] <= dreq.wdata[2:0];
      end
      if (wdt_clear_op || sleep_op)
      begin
        status_reg[ST_WDT] <= 1'b1;
      end
      else if (wdt_timeout)
      begin
        status_reg[ST_WDT] <= 1'b0;
      end
      if (wdt_clear_op)
      begin
        status_reg[ST_SLEEP] <= 1'b1;
      end
      else if (sleep_op)
      begin
        status_reg[ST_SLEEP] <= 1'b0;
      end
    end
  end

  assign status = {3'h0, status_reg[4:0]};

  // ==========================================================
  // core registers and shadow copies
  // ==========================================================
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      shadow_reg <= '0;
    end
    else if (irq_take)
    begin
      shadow_reg <= '{status_reg[2:0], acc_reg, bank_reg, latch_reg, pa_reg, pb_reg};
    end
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      acc_reg <= REG_RST;
      bank_reg <= '0;
      latch_reg <= '0;
      int_ctrl_reg <= REG_RST;
      pa_reg <= '0;
      pb_reg <= '0;
    end
    else if (restore)
    begin
      acc_reg <= shadow_reg.acc;
      bank_reg <= shadow_reg.bank;
      latch_reg <= shadow_reg.latch;
      pa_reg <= shadow_reg.pa;
      pb_reg <= shadow_reg.pb;
    end
    else if (wr_ok)
    begin
      case (eff_off)
        OFF_PA_LO: pa_reg[7:0] <= dreq.wdata;
        OFF_PA_HI: pa_reg[15:8] <= dreq.wdata;
        OFF_PB_LO: pb_reg[7:0] <= dreq.wdata;
        OFF_PB_HI: pb_reg[15:8] <= dreq.wdata;
        OFF_BANK: bank_reg <= dreq.wdata[BANK_W-1:0];
        OFF_ACC: acc_reg <= dreq.wdata;
        OFF_LATCH: latch_reg <= dreq.wdata[LATCH_W-1:0];
        OFF_INT_CTRL: int_ctrl_reg <= dreq.wdata;
        default: acc_reg <= acc_reg;
      endcase
    end
  end

  assign accumulator = acc_reg;

  // ==========================================================
  // program counter and return stack
  // ==========================================================
  assign stk_push = ce && (pc_op == CMO_PC_CALL || pc_op == CMO_PC_IRQ) && !pc_low_wr;
  assign stk_pop = ce && (pc_op == CMO_PC_RET || pc_op == CMO_PC_RETFIE) && !pc_low_wr;
  assign stk_push_data = pc_op == CMO_PC_CALL ? wrap_pc(pc_reg + 1'b1) : pc_reg;

  cmo_stack #(
    .W(STK_W),
    .DEPTH(STK_DEPTH)
  ) u_stack (
    .clk(clk),
    .resetn(resetn),
    .ce(ce),
    .push(stk_push),
    .pop(stk_pop),
    .push_data(stk_push_data),
    .top_data(stk_top),
    .overflow(stk_ovf),
    .underflow(stk_unf)
  );

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      pc_reg <= RESET_VEC;
    end
    else if (ce)
    begin
      if (pc_low_wr)
      begin
        pc_reg <= wrap_pc({latch_reg, dreq.wdata});
      end
      else
      begin
        case (pc_op)
          CMO_PC_INC: pc_reg <= wrap_pc(pc_reg + 1'b1);
          CMO_PC_JUMP: pc_reg <= wrap_pc(pc_target);
          CMO_PC_CALL: pc_reg <= wrap_pc(pc_target);
          CMO_PC_RET: pc_reg <= wrap_pc(stk_top);
          CMO_PC_RETFIE: pc_reg <= wrap_pc(stk_top);
          CMO_PC_IRQ: pc_reg <= IRQ_VEC;
          default: pc_reg <= pc_reg;
        endcase
      end
    end
  end

  assign pc = pc_reg;

  // set wins over a clear in the same cycle
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      ovf_flag_reg <= 1'b0;
      unf_flag_reg <= 1'b0;
      soft_rst_reg <= 1'b0;
    end
    else if (ce)
    begin
      ovf_flag_reg <= stk_ovf || (ovf_flag_reg && !stack_flag_clr[0]);
      unf_flag_reg <= stk_unf || (unf_flag_reg && !stack_flag_clr[1]);
      soft_rst_reg <= stack_reset_en && (stk_ovf || stk_unf);
    end
  end

  assign stack_overflow_flag = ovf_flag_reg;
  assign stack_underflow_flag = unf_flag_reg;
  assign soft_reset_req = soft_rst_reg;

  // ==========================================================
  // checks
  // ==========================================================
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn || !ce);

  stack_ovf_flag_a: assert property (stk_ovf |=> stack_overflow_flag)
    else $error("overflow flag not set");
  soft_reset_a: assert property (((stk_ovf || stk_unf) && stack_reset_en) |=>
    soft_reset_req)
    else $error("software reset missing");
  pm_extra_cycle_a: assert property ((take && pm_access && !dreq.wr) |=>
    (busy && pm_rd && !rd_valid) ##1 (rd_valid && rd_data == $past(pm_rdata[7:0])))
    else $error("program read timing wrong");
  pm_write_drop_a: assert property ((take && pm_access && dreq.wr) |=>
    (busy && !pm_rd) ##1 !rd_valid)
    else $error("program write not ignored");
  pc_wrap_a: assert property (pc[PC_W-1:PM_AW] == '0)
    else $error("program counter beyond space");
  irq_vector_a: assert property ((pc_op == CMO_PC_IRQ && !pc_low_wr) |=>
    pc == IRQ_VEC)
    else $error("interrupt vector wrong");
  status_mask_a: assert property ((alu.valid && status_wr) |=>
    status[2:0] == $past({alu_z, alu_nib, alu_c}))
    else $error("status write not masked");
  zero_flag_a: assert property ((alu.valid && alu.kind == CMO_ALU_ADD) |=>
    status[ST_Z] == (alu_result == 8'h00))
    else $error("zero flag mismatch");
  wdt_flag_a: assert property ((wdt_timeout && !wdt_clear_op && !sleep_op) |=>
    !status[ST_WDT])
    else $error("watchdog flag not cleared");
  sleep_flag_a: assert property ((sleep_op && !wdt_clear_op) |=>
    !status[ST_SLEEP] && status[ST_WDT])
    else $error("sleep flags wrong");
  unimpl_read_a: assert property ((take && !dreq.wr && !sel_ind && dreq.addr == 7'h0c) |=>
    rd_valid && rd_data == 8'h00)
    else $error("unimplemented read not zero");
  irq_restore_a: assert property ((pc_op == CMO_PC_IRQ) ##1 (pc_op == CMO_PC_RETFIE) |=>
    accumulator == $past(accumulator, 2))
    else $error("context not restored");

  pm_read_c: cover property (take && pm_access && !dreq.wr ##2 rd_valid);
  irq_return_c: cover property (pc_op == CMO_PC_IRQ ##[1:20] pc_op == CMO_PC_RETFIE);
  stack_full_c: cover property (stk_ovf);
endmodule

/* File: design/cmo_pkg.sv */
// Overview of operation
// - return stack, 16 entries of 15 bits
// - stack overflow/underflow set flags, optional reset
// - interrupt saves core registers, return restores them
// - two 16-bit pointers reach data and program
// - program memory through pointer costs extra cycle
// - pointer high bit 7 selects program low byte
// - pointer writes to program memory are ignored
// - 15-bit program counter, 32K word space
// - 2048 words implemented, higher addresses wrap
// - reset starts at 0000h, interrupt at 0004h
// - 0780h-07FFh is the high endurance area
// - 32 banks of 128 bytes, fixed partition
// - bank register selects bank for direct access
// - unimplemented data locations read as zero
// - 12-bit data address: 5 bank, 7 offset
// - core registers mirrored at start of every bank
// - flag-setting op masks status flag write
// - watchdog flag set by power, clear, sleep
// - sleep flag set by power, clear; cleared by sleep
// - zero flag follows result equal to zero
// - digit carry from bit 3, carry from bit 7
// - subtract adds complement; rotate loads carry
package cmo_pkg;
  localparam int PC_W = 15;
  localparam int PM_AW = 11;
  localparam int PM_WORDS = 2048;
  localparam int PM_DW = 14;
  localparam int DA_W = 12;
  localparam int BANK_W = 5;
  localparam int OFF_W = 7;
  localparam int PTR_W = 16;
  localparam int STK_W = 15;
  localparam int STK_DEPTH = 16;
  localparam int BANK_COUNT = 32;
  localparam int BANK_BYTES = 128;
  localparam int GPR_BYTES = 80;
  localparam int GPR_BANKS = 3;
  localparam int COMMON_BYTES = 16;
  localparam int LATCH_W = 7;
  localparam int PTR_PM_BIT = 7;
  localparam logic [PC_W-1:0] RESET_VEC = 15'h0000;
  localparam logic [PC_W-1:0] IRQ_VEC = 15'h0004;
  localparam logic [PM_AW-1:0] PM_LAST = 11'h7ff;
  localparam logic [PM_AW-1:0] HEF_LO = 11'h780;
  localparam logic [OFF_W-1:0] OFF_IND_A = 7'h00;
  localparam logic [OFF_W-1:0] OFF_IND_B = 7'h01;
  localparam logic [OFF_W-1:0] OFF_PC_LOW = 7'h02;
  localparam logic [OFF_W-1:0] OFF_STATUS = 7'h03;
  localparam logic [OFF_W-1:0] OFF_PA_LO = 7'h04;
  localparam logic [OFF_W-1:0] OFF_PA_HI = 7'h05;
  localparam logic [OFF_W-1:0] OFF_PB_LO = 7'h06;
  localparam logic [OFF_W-1:0] OFF_PB_HI = 7'h07;
  localparam logic [OFF_W-1:0] OFF_BANK = 7'h08;
  localparam logic [OFF_W-1:0] OFF_ACC = 7'h09;
  localparam logic [OFF_W-1:0] OFF_LATCH = 7'h0a;
  localparam logic [OFF_W-1:0] OFF_INT_CTRL = 7'h0b;
  localparam logic [OFF_W-1:0] OFF_GPR_LO = 7'h20;
  localparam logic [OFF_W-1:0] OFF_GPR_HI = 7'h6f;
  localparam logic [OFF_W-1:0] OFF_COMMON_LO = 7'h70;
  localparam int ST_C = 0;
  localparam int ST_NIB = 1;
  localparam int ST_Z = 2;
  localparam int ST_SLEEP = 3;
  localparam int ST_WDT = 4;
  localparam logic [7:0] STATUS_RST = 8'h18;
  localparam logic [7:0] REG_RST = 8'h00;

  typedef enum logic [2:0] {CMO_ALU_ADD, CMO_ALU_SUB, CMO_ALU_LOGIC, CMO_ALU_RLF,
                            CMO_ALU_RRF} cmo_alu_e;
  typedef enum logic [2:0] {CMO_PC_HOLD, CMO_PC_INC, CMO_PC_JUMP, CMO_PC_CALL, CMO_PC_RET,
                            CMO_PC_RETFIE, CMO_PC_IRQ} cmo_pc_e;

  typedef struct packed {
    logic valid;
    logic wr;
    logic [OFF_W-1:0] addr;
    logic [7:0] wdata;
  } cmo_dreq_s;

  typedef struct packed {
    logic valid;
    cmo_alu_e kind;
    logic [7:0] a;
    logic [7:0] b;
  } cmo_alu_s;

  typedef struct packed {
    logic [2:0] flags;
    logic [7:0] acc;
    logic [BANK_W-1:0] bank;
    logic [LATCH_W-1:0] latch;
    logic [PTR_W-1:0] pa;
    logic [PTR_W-1:0] pb;
  } cmo_shadow_s;
endpackage

/* File: design/cmo_stack.sv */
`timescale 1ns/1ps
module cmo_stack #(
  parameter int W = cmo_pkg::STK_W,
  parameter int DEPTH = cmo_pkg::STK_DEPTH
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic ce,
  input wire logic push,
  input wire logic pop,
  input wire logic [W-1:0] push_data,
  output logic [W-1:0] top_data,
  output logic overflow,
  output logic underflow
);
  import cmo_pkg::*;

  localparam int CNT_W = $clog2(DEPTH + 1);
  localparam logic [CNT_W-1:0] FULL = CNT_W'(DEPTH);

  logic [W-1:0] mem [DEPTH];
  logic [CNT_W-1:0] count_reg;

  // ==========================================================
  // storage, separate from data memory
  // ==========================================================
  always_ff @(posedge clk)
  begin
    if (ce && push && count_reg != FULL)
    begin
      mem[count_reg[$clog2(DEPTH)-1:0]] <= push_data;
    end
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      count_reg <= '0;
    end
    else if (ce)
    begin
      if (push && count_reg != FULL)
      begin
        count_reg <= count_reg + 1'b1;
      end
      else if (pop && count_reg != '0)
      begin
        count_reg <= count_reg - 1'b1;
      end
    end
  end

  // an empty stack pops zero, so a stray return lands on the reset vector
  always_comb
  begin
    top_data = '0;
    if (count_reg != '0)
    begin
      top_data = mem[$clog2(DEPTH)'(count_reg - 1'b1)];
    end
  end

  assign overflow = push && count_reg == FULL;
  assign underflow = pop && count_reg == '0;
endmodule

/* File: test/cmo_pm_model.sv */
`timescale 1ns/1ps
// ==========
// program word source
module cmo_pm_model (
  input wire logic clk,
  input wire logic pm_rd,
  input wire logic [cmo_pkg::PM_AW-1:0] pm_addr,
  output logic [cmo_pkg::PM_DW-1:0] pm_rdata
);
  import cmo_pkg::*;
  logic [PM_DW-1:0] churn = 14'h0000;
  always @(posedge clk) churn <= churn + 14'h1555;
  // low byte is the inverted address; outside a read the bus churns
  assign pm_rdata = pm_rd ? {pm_addr[2:0], ~pm_addr} : churn;
endmodule

/* File: test/cmo_core_tb.sv */
`timescale 1ns/1ps
module cmo_core_tb;
  import cmo_pkg::*;
  logic clk = 0, resetn = 0, ce = 1, busy, rd_valid, pm_rd, pm_hef_sel;
  logic wdt_clear_op = 0, sleep_op = 0, wdt_timeout = 0, stack_reset_en = 0;
  logic [1:0] stack_flag_clr = 2'b00;
  logic ovf, unf, soft_reset_req, saw_busy, saw_hef;
  logic [7:0] rd_data, alu_result, status, accumulator, d;
  logic [PC_W-1:0] pc, pc_target = 15'h0000;
  logic [PM_AW-1:0] pm_addr;
  logic [PM_DW-1:0] pm_rdata;
  cmo_dreq_s dreq = '0;
  cmo_alu_s alu = '0;
  cmo_pc_e pc_op = CMO_PC_HOLD;
  int fail_count = 0, compares = 0, cyc = 0, srst_count = 0;
  cmo_alu_e ak[8] = '{CMO_ALU_ADD, CMO_ALU_ADD, CMO_ALU_SUB, CMO_ALU_SUB,
                      CMO_ALU_RLF, CMO_ALU_RRF, CMO_ALU_RRF, CMO_ALU_LOGIC};
  logic [7:0] aa[8] = '{8'hff, 8'h0f, 8'h05, 8'h03, 8'h80, 8'h01, 8'h02, 8'h00};
  logic [7:0] ab[8] = '{8'h01, 8'h01, 8'h03, 8'h05, 8'h00, 8'h00, 8'h00, 8'h00};
  logic [7:0] af[8] = '{8'h07, 8'h02, 8'h03, 8'h00, 8'h01, 8'h01, 8'h00, 8'h04};
  logic [7:0] ar[4] = '{8'h00, 8'h10, 8'h02, 8'hfe};

  cmo_core uut (.clk(clk), .resetn(resetn), .ce(ce), .dreq(dreq), .busy(busy),
    .rd_data(rd_data), .rd_valid(rd_valid), .alu(alu), .alu_result(alu_result),
    .pc_op(pc_op), .pc_target(pc_target), .pc(pc), .pm_rd(pm_rd), .pm_addr(pm_addr),
    .pm_rdata(pm_rdata), .pm_hef_sel(pm_hef_sel), .wdt_clear_op(wdt_clear_op),
    .sleep_op(sleep_op), .wdt_timeout(wdt_timeout), .stack_reset_en(stack_reset_en),
    .stack_flag_clr(stack_flag_clr), .stack_overflow_flag(ovf),
    .stack_underflow_flag(unf), .soft_reset_req(soft_reset_req), .status(status),
    .accumulator(accumulator));
  cmo_pm_model pm (.clk(clk), .pm_rd(pm_rd), .pm_addr(pm_addr), .pm_rdata(pm_rdata));

  // ==========
  // clock, watchdog on the run, soft reset counter
  always #25 clk = ~clk;
  always @(posedge clk)
  begin
    cyc++;
    if (soft_reset_req === 1'b1) srst_count++;
    if (cyc == 3000)
    begin
      fail_count++;
      conclude();
    end
  end

  // ==========
  // access tasks
  task automatic chk(input string n, input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp)
    begin
      fail_count++;
      $display("unexpected %s: expected %h seen %h", n, exp, got);
    end
  endtask
  task automatic rd(input logic [6:0] a, output logic [7:0] v);
    int n;
    @(negedge clk) dreq = '{1'b1, 1'b0, a, 8'h00};
    @(negedge clk) dreq.valid = 1'b0;
    saw_busy = busy;
    saw_hef = pm_hef_sel;
    n = 0;
    while (rd_valid !== 1'b1 && n < 4)
    begin
      @(negedge clk);
      n++;
    end
    chk("rd_valid", rd_valid, 1'b1);
    v = rd_data;
  endtask
  task automatic wr(input logic [6:0] a, input logic [7:0] v);
    @(negedge clk) dreq = '{1'b1, 1'b1, a, v};
    @(negedge clk) dreq.valid = 1'b0;
    while (busy === 1'b1) @(negedge clk);
  endtask
  task automatic op(input cmo_alu_e k, input logic [7:0] a, input logic [7:0] b);
    @(negedge clk) alu = '{1'b1, k, a, b};
    @(negedge clk) alu.valid = 1'b0;
  endtask
  task automatic pco(input cmo_pc_e o, input logic [14:0] t);
    @(negedge clk) pc_op = o;
    pc_target = t;
    @(negedge clk) pc_op = CMO_PC_HOLD;
  endtask
  task automatic ev(input logic [2:0] e);
    @(negedge clk) {wdt_clear_op, sleep_op, wdt_timeout} = e;
    @(negedge clk) {wdt_clear_op, sleep_op, wdt_timeout} = 3'b000;
  endtask
  task automatic conclude;
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // ==========
  // tests
  initial
  begin
    repeat (4) @(negedge clk);
    resetn = 1'b1;
    chk("pc", pc, RESET_VEC);
    chk("status", status, STATUS_RST);
    $display("reset test done");
    wr(OFF_ACC, 8'h3c);
    chk("accumulator", accumulator, 8'h3c);
    wr(OFF_BANK, 8'h02);
    rd(OFF_ACC, d);
    chk("acc mirror", d, 8'h3c);
    chk("busy", saw_busy, 1'b0);
    wr(OFF_GPR_LO, 8'h77);
    wr(OFF_COMMON_LO, 8'h99);
    wr(OFF_BANK, 8'h05);
    wr(OFF_GPR_LO, 8'h55);
    rd(OFF_GPR_LO, d);
    chk("bank5 gpr", d, 8'h00);
    rd(7'h0c, d);
    chk("periph area", d, 8'h00);
    rd(OFF_COMMON_LO, d);
    chk("common", d, 8'h99);
    wr(OFF_BANK, 8'h02);
    rd(OFF_GPR_LO, d);
    chk("bank2 gpr", d, 8'h77);
    wr(OFF_PB_HI, 8'h00);
    wr(OFF_PB_LO, 8'ha0);
    wr(OFF_IND_B, 8'h33);
    wr(OFF_BANK, 8'h01);
    rd(OFF_GPR_LO, d);
    chk("ptr write", d, 8'h33);
    $display("data test done");
    wr(OFF_PA_HI, 8'h87);
    wr(OFF_PA_LO, 8'h85);
    rd(OFF_IND_A, d);
    chk("pm byte", d, 8'h7a);
    chk("pm busy", saw_busy, 1'b1);
    chk("hef", saw_hef, 1'b1);
    wr(OFF_IND_A, 8'h00);
    rd(OFF_IND_A, d);
    chk("pm kept", d, 8'h7a);
    wr(OFF_PA_HI, 8'h80);
    wr(OFF_PA_LO, 8'h05);
    rd(OFF_IND_A, d);
    chk("pm byte", d, 8'hfa);
    chk("hef", saw_hef, 1'b0);
    $display("program read test done");
    wr(OFF_STATUS, 8'h05);
    chk("status wr", status, 8'h1d);
    @(negedge clk) dreq = '{1'b1, 1'b1, OFF_STATUS, 8'h00};
    alu = '{1'b1, CMO_ALU_ADD, 8'hff, 8'h01};
    @(negedge clk) dreq.valid = 1'b0;
    alu.valid = 1'b0;
    chk("status masked", status, 8'h1f);
    for (int i = 0; i < 8; i++)
    begin
      op(ak[i], aa[i], ab[i]);
      chk("flags", status, 8'h18 | af[i]);
      if (i < 4) chk("alu_result", alu_result, ar[i]);
    end
    ev(3'b010);
    chk("sleep", status[4:3], 2'b10);
    ev(3'b001);
    chk("timeout", status[4:3], 2'b00);
    ev(3'b100);
    chk("clear", status[4:3], 2'b11);
    $display("status test done");
    pco(CMO_PC_JUMP, 15'h0805);
    chk("pc wrap", pc, 15'h0005);
    pco(CMO_PC_JUMP, 15'h0100);
    stack_reset_en = 1'b1;
    repeat (16) pco(CMO_PC_CALL, 15'h0200);
    repeat (3) @(negedge clk);
    chk("ovf", ovf, 1'b0);
    pco(CMO_PC_CALL, 15'h0200);
    repeat (3) @(negedge clk);
    chk("ovf", ovf, 1'b1);
    chk("soft reset", srst_count, 1);
    stack_flag_clr = 2'b01;
    stack_reset_en = 1'b0;
    @(negedge clk) stack_flag_clr = 2'b00;
    repeat (16) pco(CMO_PC_RET, 15'h0000);
    chk("ret", pc, 15'h0101);
    chk("unf", unf, 1'b0);
    pco(CMO_PC_RET, 15'h0000);
    repeat (3) @(negedge clk);
    chk("unf", unf, 1'b1);
    chk("ovf", ovf, 1'b0);
    chk("soft reset", srst_count, 1);
    $display("stack test done");
    pco(CMO_PC_JUMP, 15'h0123);
    wr(OFF_ACC, 8'h5a);
    pco(CMO_PC_IRQ, 15'h0000);
    chk("irq vector", pc, IRQ_VEC);
    wr(OFF_ACC, 8'h11);
    pco(CMO_PC_RETFIE, 15'h0000);
    chk("retfie pc", pc, 15'h0123);
    chk("acc restore", accumulator, 8'h5a);
    // interrupt and return back to back, accumulator overwritten meanwhile
    @(negedge clk) pc_op = CMO_PC_IRQ;
    dreq = '{1'b1, 1'b1, OFF_ACC, 8'h22};
    @(negedge clk) pc_op = CMO_PC_RETFIE;
    dreq.valid = 1'b0;
    @(negedge clk) pc_op = CMO_PC_HOLD;
    chk("quick return pc", pc, 15'h0123);
    chk("quick restore", accumulator, 8'h5a);
    // clock enable low freezes interrupt entry and register writes
    @(negedge clk) ce = 1'b0;
    pc_op = CMO_PC_IRQ;
    dreq = '{1'b1, 1'b1, OFF_ACC, 8'h66};
    @(negedge clk) ce = 1'b1;
    pc_op = CMO_PC_HOLD;
    dreq.valid = 1'b0;
    chk("frozen pc", pc, 15'h0123);
    chk("frozen acc", accumulator, 8'h5a);
    $display("interrupt test done");
    conclude();
  end
endmodule
